// file: rx_out_cfg.svh
// constants and register map of the receive output and loss report block
//
// What this block does
// [R1] single rail: decoded data on selected edge
// [R2] inversion bit b3 sets data active level
// [R3] powered down: outputs high-z or low by b6
// [R4] dual rail nrz: undecoded rails on edge
// [R5] dual rail rz: return-to-zero rails on edge
// [R6] sliced mode: raw slicer rails, no decoding
// [R7] rails follow tip polarity, ring in differential
// [R8] indication source chosen by field b7~5
// [R9] indication active high, updated on edge unless source is clock
// [R10] indication on negative pin or clock pin
// [R11] recovered clock output, edge select b4
// [R12] loss of signal: clock high or reference
// [R13] 22 loss bits serial, 7 low slots
// [R14] marker high one slot in twenty-nine
// [R15] serial status changes on status rising edge
// [R16] status clock off: status pins high-z
// [R17] line inputs high-z: pin, mclk, reset
// [R18] channel power-down bit b5 floats line inputs
// [R19] far end samples on falling status clock edge
// [R20] status clock enable and rate select
// [R21] channel 0 aligned to marker, ascending
// [R22] far end realigns to marker, drops pads
`ifndef RX_OUT_CFG_SVH
`define RX_OUT_CFG_SVH

`define CH_NUM        22
`define SLOT_NUM      29
`define SLOT_LAST     5'h1C
`define CH_LAST_SLOT  5'h15
`define CLK_NS        4
`define FAST_PER_NS   488
`define SLOW_PER_NS   125000
`define FAST_HALF_CYC ((`FAST_PER_NS / 2) / `CLK_NS)
`define SLOW_HALF_CYC ((`SLOW_PER_NS / 2) / `CLK_NS)
`define DIV_W         14

`define CH_REG_END    8'h2C
`define GLB_ADDR      8'h30
`define LOS_ADDR0     8'h31
`define LOS_ADDR1     8'h32
`define LOS_ADDR2     8'h33

`define A_SE          0
`define A_PDN         5
`define A_HIZ         6
`define A_LOSM        7
`define B_FMT_LO      0
`define B_INV         3
`define B_EDGE        4
`define B_SEL_LO      5
`define G_EN          0
`define G_FAST        1
`define G_LINE_EN     2
`define G_SRST        7

`define IND_PAT       3'h0
`define IND_AIS       3'h1
`define IND_EXZ       3'h2
`define IND_BPV       3'h3
`define IND_ERR       3'h4
`define IND_LOS       3'h5
`define IND_RCLK      3'h6
`define IND_XOR       3'h7

`endif

// file: rx_out_pkg.sv
// types shared by the receive output and loss report block
package rx_out_pkg;

    typedef enum logic [1:0] {
        FMT_SINGLE   = 2'h0,
        FMT_DUAL_NRZ = 2'h1,
        FMT_DUAL_RZ  = 2'h3,
        FMT_SLICED   = 2'h2
    } rx_fmt_t;

    typedef struct packed {
        logic rx_recovered_clock;
        logic decoded_data;
        logic rx_line_tip_pos;
        logic rx_line_tip_neg;
        logic rx_line_ring_pos;
        logic rx_line_ring_neg;
        logic pattern_detect;
        logic line_alarm_indication;
        logic line_excess_zeroes;
        logic line_bipolar_violation;
        logic line_los;
    } chan_in_t;

    typedef struct packed {
        logic rx_positive_rail;
        logic rx_positive_rail_oe;
        logic rx_negative_rail;
        logic rx_negative_rail_oe;
        logic rx_recovered_clock;
        logic rx_recovered_clock_oe;
        logic line_hiz;
    } chan_out_t;

endpackage

// file: rx_chan_output.sv
// one channel of receive system-side output logic
`timescale 1ns/1ps
`include "rx_out_cfg.svh"

module rx_chan_output (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [7:0]            i_cfg_a,
    input  wire logic [7:0]            i_cfg_b,
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_line_hiz_req,
    input  wire rx_out_pkg::chan_in_t  i_in,
    output rx_out_pkg::chan_out_t      o_pins
);
    rx_out_pkg::chan_in_t  in_s1_reg;
    rx_out_pkg::chan_in_t  in_s2_reg;
    rx_out_pkg::chan_out_t pins_next;
    rx_out_pkg::rx_fmt_t   fmt;
    logic                  clk_d_reg;
    logic                  act;
    logic                  pos_raw;
    logic                  neg_raw;
    logic                  ind_src;
    logic                  ind_out;
    logic                  clk_now;
    logic                  rz_gate;
    logic                  inv;
    logic [2:0]            sel;
    logic                  dat_p_reg;
    logic                  dat_n_reg;
    logic                  ind_reg;

    assign fmt = rx_out_pkg::rx_fmt_t'(i_cfg_b[`B_FMT_LO +: 2]);
    assign sel = i_cfg_b[`B_SEL_LO +: 3];
    assign inv = i_cfg_b[`B_INV];

    always_ff @(posedge i_sys_clk) begin
        in_s1_reg <= i_in;
        in_s2_reg <= in_s1_reg;
        clk_d_reg <= in_s2_reg.rx_recovered_clock;
    end

    // --------------------------------------------------------------
    // edge, rails and indication source
    // --------------------------------------------------------------
    always_comb begin
        act = i_cfg_b[`B_EDGE] ? (clk_d_reg & ~in_s2_reg.rx_recovered_clock)
                               : (~clk_d_reg & in_s2_reg.rx_recovered_clock); // see [R11]
        pos_raw = in_s2_reg.rx_line_tip_pos
                & (i_cfg_a[`A_SE] | in_s2_reg.rx_line_ring_neg); // see [R7]
        neg_raw = in_s2_reg.rx_line_tip_neg
                & (i_cfg_a[`A_SE] | in_s2_reg.rx_line_ring_pos); // see [R7]
        clk_now = in_s2_reg.line_los ? (~i_cfg_a[`A_LOSM] | i_ref_clk)
                                     : in_s2_reg.rx_recovered_clock; // see [R12]
        unique case (sel) // see [R8]
            `IND_PAT:  ind_src = in_s2_reg.pattern_detect;
            `IND_AIS:  ind_src = in_s2_reg.line_alarm_indication;
            `IND_EXZ:  ind_src = in_s2_reg.line_excess_zeroes;
            `IND_BPV:  ind_src = in_s2_reg.line_bipolar_violation;
            `IND_ERR:  ind_src = in_s2_reg.line_excess_zeroes
                               | in_s2_reg.line_bipolar_violation;
            `IND_LOS:  ind_src = in_s2_reg.line_los;
            `IND_RCLK: ind_src = clk_now;
            `IND_XOR:  ind_src = pos_raw ^ neg_raw;
        endcase
        ind_out = (sel == `IND_RCLK) ? clk_now : ind_reg; // see [R9]
        rz_gate = (fmt == rx_out_pkg::FMT_DUAL_RZ) ? clk_now : 1'b1; // see [R5]
    end

    // data held from one active edge to the next
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            dat_p_reg <= 1'b0;
            dat_n_reg <= 1'b0;
            ind_reg   <= 1'b0;
        end else if (act) begin
            dat_p_reg <= (fmt == rx_out_pkg::FMT_SINGLE) ? in_s2_reg.decoded_data
                                                         : pos_raw; // see [R1] [R4]
            dat_n_reg <= neg_raw; // see [R4]
            ind_reg   <= ind_src; // see [R9]
        end
    end

    // --------------------------------------------------------------
    // pin multiplexing
    // --------------------------------------------------------------
    always_comb begin
        pins_next = '0;
        pins_next.line_hiz = i_line_hiz_req | i_cfg_a[`A_PDN]; // see [R18]
        unique case (fmt)
            rx_out_pkg::FMT_SINGLE: begin
                pins_next.rx_positive_rail   = dat_p_reg ^ inv; // see [R2]
                pins_next.rx_negative_rail   = ind_out; // see [R10]
                pins_next.rx_recovered_clock = clk_now;
            end
            rx_out_pkg::FMT_DUAL_NRZ, rx_out_pkg::FMT_DUAL_RZ: begin
                pins_next.rx_positive_rail   = (dat_p_reg & rz_gate) ^ inv; // see [R2]
                pins_next.rx_negative_rail   = (dat_n_reg & rz_gate) ^ inv;
                pins_next.rx_recovered_clock = clk_now;
            end
            rx_out_pkg::FMT_SLICED: begin
                pins_next.rx_positive_rail   = pos_raw ^ inv; // see [R6]
                pins_next.rx_negative_rail   = neg_raw ^ inv;
                pins_next.rx_recovered_clock = ind_out; // see [R10]
            end
        endcase
        if (i_cfg_a[`A_PDN]) begin
            pins_next.rx_positive_rail   = 1'b0; // see [R3]
            pins_next.rx_negative_rail   = 1'b0;
            pins_next.rx_recovered_clock = 1'b0;
        end
        pins_next.rx_positive_rail_oe   = ~(i_cfg_a[`A_PDN] & i_cfg_a[`A_HIZ]);
        pins_next.rx_negative_rail_oe   = pins_next.rx_positive_rail_oe;
        pins_next.rx_recovered_clock_oe = pins_next.rx_positive_rail_oe;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_pins <= '0;
            o_pins.line_hiz <= 1'b1;
        end else begin
            o_pins <= pins_next;
        end
    end

    pdn_hiz_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [R3]
        i_cfg_a[`A_PDN] && i_cfg_a[`A_HIZ] |=> !o_pins.rx_positive_rail_oe
            && !o_pins.rx_recovered_clock_oe)
        else $error("powered down channel still drives");

    pdn_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [R3]
        i_cfg_a[`A_PDN] && !i_cfg_a[`A_HIZ] |=> o_pins.rx_positive_rail_oe
            && !o_pins.rx_positive_rail && !o_pins.rx_negative_rail)
        else $error("powered down channel not driven low");

endmodule

// file: rx_system_output_and_los_report.sv
// receive system outputs of all channels and the serial loss reporter
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "rx_out_cfg.svh"

module rx_system_output_and_los_report #(
    parameter int SLOW_HALF_CYC = `SLOW_HALF_CYC
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [7:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic [7:0]                 o_rdata,
    input  wire logic                  i_internal_ref_clock,
    input  wire logic                  i_global_rx_impedance_pin,
    input  wire logic                  i_master_clock_lost,
    input  wire rx_out_pkg::chan_in_t  i_chan [`CH_NUM],
    output rx_out_pkg::chan_out_t      o_chan [`CH_NUM],
    output logic                       o_status_clock_out,
    output logic                       o_status_clock_out_oe,
    output logic                       o_serial_line_loss_status,
    output logic                       o_serial_line_loss_status_oe,
    output logic                       o_chan0_frame_marker,
    output logic                       o_chan0_frame_marker_oe
);
    logic [7:0]             rx_config_a_reg [`CH_NUM];
    logic [7:0]             rx_config_b_reg [`CH_NUM];
    logic [7:0]             glb_reg;
    logic                   srst_reg;
    logic                   cfg_rst_n;
    logic [`CH_NUM-1:0]     los_s1_reg;
    logic [`CH_NUM-1:0]     los_s2_reg;
    logic [2:0]             ref_s1_reg;
    logic                   ref_s2_reg;
    logic                   imp_s2_reg;
    logic                   mcl_s2_reg;
    logic                   line_hiz_req;
    logic                   ch_hit;
    logic [4:0]             ch_idx;
    logic [7:0]             rdata_next;
    logic [`DIV_W-1:0]      div_cnt_reg;
    logic [`DIV_W-1:0]      half_cyc;
    logic                   div_wrap;
    logic                   st_rise;
    logic [4:0]             slot_reg;
    logic [4:0]             out_slot_reg;
    logic [4:0]             rise_cnt_reg;
    logic                   st_en;
    logic [`DIV_W-1:0]      hi_cnt_reg;

    assign cfg_rst_n = i_rst_n & ~srst_reg;
    assign ch_hit    = (i_addr < `CH_REG_END);
    assign ch_idx    = i_addr[5:1];
    assign st_en     = glb_reg[`G_EN];

    // --------------------------------------------------------------
    // synchronisers for pins from other domains
    // --------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        los_s2_reg <= los_s1_reg;
        ref_s2_reg <= ref_s1_reg[0];
        imp_s2_reg <= ref_s1_reg[1];
        mcl_s2_reg <= ref_s1_reg[2];
        ref_s1_reg <= {i_master_clock_lost, i_global_rx_impedance_pin,
                       i_internal_ref_clock};
    end

    generate
        for (genvar k = 0; k < `CH_NUM; k++) begin : g_los_sync
            always_ff @(posedge i_sys_clk) begin
                los_s1_reg[k] <= i_chan[k].line_los;
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // register file
    // --------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n) begin
            for (int k = 0; k < `CH_NUM; k++) begin
                rx_config_a_reg[k] <= 8'h00;
                rx_config_b_reg[k] <= 8'h00;
            end
        end else if (i_wr && ch_hit) begin
            if (i_addr[0]) begin
                rx_config_b_reg[ch_idx] <= i_wdata;
            end else begin
                rx_config_a_reg[ch_idx] <= i_wdata;
            end
        end
    end

    // global control; the reset bit clears itself
    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n) begin
            glb_reg <= 8'h00;
        end else if (i_wr && i_addr == `GLB_ADDR) begin
            glb_reg <= {1'b0, i_wdata[6:0]};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            srst_reg <= 1'b0;
        end else begin
            srst_reg <= i_wr && (i_addr == `GLB_ADDR) && i_wdata[`G_SRST];
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        if (ch_hit) begin
            rdata_next = i_addr[0] ? rx_config_b_reg[ch_idx] : rx_config_a_reg[ch_idx];
        end else begin
            unique case (i_addr)
                `GLB_ADDR:  rdata_next = glb_reg;
                `LOS_ADDR0: rdata_next = los_s2_reg[7:0];
                `LOS_ADDR1: rdata_next = los_s2_reg[15:8];
                `LOS_ADDR2: rdata_next = {2'h0, los_s2_reg[21:16]};
                default:    rdata_next = 8'h00;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rdata_next : 8'h00;
        end
    end

    // --------------------------------------------------------------
    // receive line impedance and per-channel outputs
    // --------------------------------------------------------------
    assign line_hiz_req = ~glb_reg[`G_LINE_EN] | ~imp_s2_reg | mcl_s2_reg; // see [R17]

    generate
        for (genvar k = 0; k < `CH_NUM; k++) begin : g_chan
            rx_chan_output u_chan (
                .i_sys_clk      (i_sys_clk),
                .i_rst_n        (cfg_rst_n),
                .i_cfg_a        (rx_config_a_reg[k]),
                .i_cfg_b        (rx_config_b_reg[k]),
                .i_ref_clk      (ref_s2_reg),
                .i_line_hiz_req (line_hiz_req),
                .i_in           (i_chan[k]),
                .o_pins         (o_chan[k])
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // status clock divider
    // --------------------------------------------------------------
    assign half_cyc = glb_reg[`G_FAST] ? `DIV_W'(`FAST_HALF_CYC)
                                       : `DIV_W'(SLOW_HALF_CYC); // see [R20]
    assign div_wrap = (div_cnt_reg >= half_cyc - `DIV_W'(1));
    assign st_rise  = div_wrap & ~o_status_clock_out;

    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n || !st_en) begin
            div_cnt_reg <= '0;
        end else if (div_wrap) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + `DIV_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n || !st_en) begin
            o_status_clock_out <= 1'b0;
        end else if (div_wrap) begin
            o_status_clock_out <= ~o_status_clock_out;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n) begin
            o_status_clock_out_oe        <= 1'b0;
            o_serial_line_loss_status_oe <= 1'b0;
            o_chan0_frame_marker_oe      <= 1'b0;
        end else begin
            o_status_clock_out_oe        <= st_en; // see [R20]
            o_serial_line_loss_status_oe <= st_en; // see [R16]
            o_chan0_frame_marker_oe      <= st_en; // see [R16]
        end
    end

    // --------------------------------------------------------------
    // serial loss status frame
    // --------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n || !st_en) begin
            slot_reg <= 5'h00;
        end else if (st_rise) begin
            slot_reg <= (slot_reg == `SLOT_LAST) ? 5'h00 : slot_reg + 5'h01; // see [R14]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n || !st_en) begin
            o_serial_line_loss_status <= 1'b0;
            o_chan0_frame_marker      <= 1'b0;
        end else if (st_rise) begin
            o_serial_line_loss_status <= (slot_reg <= `CH_LAST_SLOT)
                                       ? los_s2_reg[slot_reg] : 1'b0; // see [R13] [R21]
            o_chan0_frame_marker      <= (slot_reg == 5'h00); // see [R14] [R15]
        end
    end

    // --------------------------------------------------------------
    // helper state for checks
    // --------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n || !st_en) begin
            out_slot_reg <= 5'h00;
            rise_cnt_reg <= 5'h00;
        end else if (st_rise) begin
            out_slot_reg <= slot_reg;
            rise_cnt_reg <= (slot_reg == 5'h00) ? 5'h01 : rise_cnt_reg + 5'h01;
        end
    end

    // fast-rate high time, counted only from a rise seen in fast mode
    always_ff @(posedge i_sys_clk) begin
        if (!cfg_rst_n || !st_en || !glb_reg[`G_FAST]) begin
            hi_cnt_reg <= '0;
        end else if (st_rise) begin
            hi_cnt_reg <= `DIV_W'(1);
        end else if (o_status_clock_out && !div_wrap && hi_cnt_reg != '0) begin
            hi_cnt_reg <= hi_cnt_reg + `DIV_W'(1);
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    marker_period_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n) // see [R14]
        st_en && st_rise && slot_reg == 5'h00 && rise_cnt_reg != 5'h00
            |-> rise_cnt_reg == 5'(`SLOT_NUM))
        else $error("marker period is not twenty-nine slots");

    pad_slots_low_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n) // see [R13]
        st_en && out_slot_reg > `CH_LAST_SLOT && !$rose(o_status_clock_out)
            |-> !o_serial_line_loss_status)
        else $error("padding slot not low");

    chan0_slot_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n) // see [R21]
        $rose(o_chan0_frame_marker) |-> o_serial_line_loss_status == $past(los_s2_reg[0]))
        else $error("channel 0 not aligned with marker");

    status_edge_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n) // see [R15]
        $changed(o_serial_line_loss_status) && st_en |-> $rose(o_status_clock_out))
        else $error("serial status changed off the rising edge");

    status_hiz_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n) // see [R16]
        !st_en |=> !o_serial_line_loss_status_oe && !o_chan0_frame_marker_oe
            && !o_status_clock_out_oe)
        else $error("status pins driven while disabled");

    fast_half_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n) // see [R20]
        $fell(o_status_clock_out) && hi_cnt_reg != '0
            |-> hi_cnt_reg == `DIV_W'(`FAST_HALF_CYC))
        else $error("fast status clock half period wrong");

    status_on_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n) // see [R20]
        st_en |=> o_status_clock_out_oe && o_serial_line_loss_status_oe
            && o_chan0_frame_marker_oe)
        else $error("status pins not driven while enabled");

    line_hiz_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [R17]
        (!imp_s2_reg || mcl_s2_reg || !glb_reg[`G_LINE_EN]) |=> o_chan[0].line_hiz
            && o_chan[`CH_NUM-1].line_hiz)
        else $error("line inputs not floated");

    srst_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see [R17]
        srst_reg |=> !glb_reg[`G_LINE_EN] ##1 o_chan[0].line_hiz)
        else $error("software reset left line inputs enabled");

    read_glb_a: assert property (@(posedge i_sys_clk) disable iff (!cfg_rst_n)
        i_rd && i_addr == `GLB_ADDR && !srst_reg |=> o_rdata == $past(glb_reg))
        else $error("global read data wrong");

endmodule

// file: los_frame_sink.sv
// far-end model collecting serial loss report frames
`timescale 1ns/1ps

module los_frame_sink (
    input  wire logic   i_sys_clk,
    input  wire logic   i_status_clk,
    input  wire logic   i_status_oe,
    input  wire logic   i_serial,
    input  wire logic   i_marker,
    output logic [21:0] o_frame,
    output int          o_frames,
    output int          o_faults,
    output int          o_period
);
    logic        clk_q = 1'b0;
    logic        synced = 1'b0;
    logic [21:0] acc = '0;
    int          slot = 0;
    int          cnt = 0;
    initial {o_frame, o_frames, o_faults, o_period} = '0;
    // samples mid-slot, on the falling status clock edge
    always @(posedge i_sys_clk) begin
        clk_q <= i_status_clk;
        cnt++;
        if (!clk_q && i_status_clk) begin
            o_period = cnt;
            cnt = 0;
        end
        if (!i_status_oe) begin
            synced = 1'b0;
        end else if (clk_q && !i_status_clk) begin
            if (i_marker) begin
                if (synced && slot != 28) o_faults++;
                if (synced) o_frame = acc;
                if (synced) o_frames++;
                synced = 1'b1;
                slot = 0;
            end else begin
                slot++;
            end
            if (slot < 22) acc[slot] = i_serial;
            else if (synced && (i_serial || slot > 28)) o_faults++;
        end
    end
endmodule

// file: rx_system_output_and_los_report_bench.sv
// self-checking bench of the receive output and loss report block
`timescale 1ns/1ps
`include "rx_out_cfg.svh"

module rx_system_output_and_los_report_bench;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        ref_clk = 1'b0, lclk = 1'b0, imp_pin = 1'b1, mclk_lost = 1'b0;
    logic [7:0]  addr = '0, wdata = '0, rdata;
    logic [5:0]  st;
    logic [21:0] frame, pat = 22'h2A5C3;
    logic [3:0]  seen;
    int          frames, faults, period, bad_count = 0, checks_done = 0;
    rx_out_pkg::chan_in_t  chan_in [`CH_NUM], din [`CH_NUM];
    rx_out_pkg::chan_out_t chan_out [`CH_NUM];
    // cfg a, cfg b, line inputs, expected {pos, neg, clock high seen, clock low seen}
    logic [31:0] cases [15] = '{32'h0000210F, 32'h00282087, 32'h00200087, 32'h00400047,
        32'h00600027, 32'h00800047, 32'h00C00007, 32'h00A00016, 32'h80A00017,
        32'h0001120B, 32'h00090C0B, 32'h00030C07, 32'h01021409, 32'h01E2100A,
        32'h0010200B};

    rx_system_output_and_los_report #(.SLOW_HALF_CYC(8)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_internal_ref_clock(ref_clk), .i_global_rx_impedance_pin(imp_pin),
        .i_master_clock_lost(mclk_lost), .i_chan(din), .o_chan(chan_out),
        .o_status_clock_out(st[5]), .o_status_clock_out_oe(st[4]),
        .o_serial_line_loss_status(st[3]), .o_serial_line_loss_status_oe(st[2]),
        .o_chan0_frame_marker(st[1]), .o_chan0_frame_marker_oe(st[0]));
    los_frame_sink MODEL (.i_sys_clk(clk), .i_status_clk(st[5]), .i_status_oe(st[4]),
        .i_serial(st[3]), .i_marker(st[1]), .o_frame(frame), .o_frames(frames),
        .o_faults(faults), .o_period(period));

    initial forever #2 clk = ~clk;
    initial #1 forever #24 lclk = ~lclk;
    initial #3 forever #244 ref_clk = ~ref_clk;
    always_comb foreach (din[k]) din[k] = rx_out_pkg::chan_in_t'(chan_in[k] | {lclk, 10'h000});

    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask
    task automatic wait_frames(input int n);
        int goal;
        goal = frames + n;
        for (int j = 0; j < 20000 && frames < goal; j++) @(posedge clk);
        chk(32'(frames >= goal), 32'h1);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        chan_in = '{default: '0};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({chan_out[0].line_hiz, st[4], st[2], st[0]}, 4'h8);
        wr_reg(8'h01, 8'hA9);
        wr_reg(8'h40, 8'hFF);
        rd_chk(8'h01, 8'hA9);
        rd_chk(8'h40, 8'h00);
        wr_reg(`GLB_ADDR, 8'h84);
        rd_chk(8'h01, 8'h00);
        wr_reg(`GLB_ADDR, 8'h04);
        settle();
        chk(chan_out[0].line_hiz, 1'b0);
        imp_pin <= 1'b0;
        settle();
        chk(chan_out[5].line_hiz, 1'b1);
        {imp_pin, mclk_lost} <= 2'b11;
        settle();
        chk(chan_out[21].line_hiz, 1'b1);
        mclk_lost <= 1'b0;
        wr_reg(8'h00, 8'h20);
        settle();
        chk({chan_out[0][6:0], chan_out[1].line_hiz}, 8'h56);
        wr_reg(8'h00, 8'h60);
        settle();
        chk(chan_out[0][6:1], 6'h00);
        $display("test registers and line control done");
        foreach (cases[i]) begin
            wr_reg(8'h00, cases[i][31:24]);
            wr_reg(8'h01, cases[i][23:16]);
            chan_in[0] <= rx_out_pkg::chan_in_t'(cases[i][14:4]);
            repeat (30) @(posedge clk);
            seen = '0;
            repeat (130) begin
                @(posedge clk);
                seen |= {chan_out[0][6], chan_out[0][4], chan_out[0][2], !chan_out[0][2]};
            end
            chk(seen[3:2], cases[i][3:2]);
            chk(seen[1:0], cases[i][1:0]);
        end
        $display("test channel outputs done");
        foreach (chan_in[k]) chan_in[k] <= rx_out_pkg::chan_in_t'(11'(pat[k]));
        settle();
        rd_chk(`LOS_ADDR0, pat[7:0]);
        rd_chk(`LOS_ADDR2, {2'h0, pat[21:16]});
        for (int m = 5; m < 8; m += 2) begin
            wr_reg(`GLB_ADDR, 8'(m));
            wait_frames(3);
            chk(frame, pat);
            chk(period, m == 5 ? 16 : 122);
            chk({st[4], st[2], st[0]}, 3'h7);
            wr_reg(`GLB_ADDR, 8'h04);
            settle();
            chk({st[4], st[2], st[0]}, 3'h0);
        end
        chk(faults, 0);
        $display("test loss report done");
        end_of_test();
    end

    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule
